// ---- hw/ssw_top.sv ----
// Purpose: Output and monitoring logic of a transponder safety switch.
// Assumes: Actuator detection and readiness come from same-clock logic.
// Notes:   Safety path never reads any diagnostic state.
//
// Contract
// - Both safety outputs off is the safe state; fall back whenever unsure.
// - No actuator: both safety outputs low, signal output low outside diagnostic mode.
// - Actuator, ready and no lock: each output follows its input, signal output high outside diagnostic mode.
// - One input falls while the other stays high: flash input indicator.
// - That input rising again: plausibility error and lock of both safety outputs.
// - Lock and unequal state clear only after both inputs were low.
// - Diagnostic input used only when a fieldbus module is detected.
// - In diagnostic mode the signal pin transmits diagnostic data.
// - Up to 16 chained sensors addressed on one fieldbus module.
// - Diagnostic link is re-established after every power-up.
// - Answer status, configuration polls and action requests.
// - Diagnostics are independent of the safety signal path.

`timescale 1ns/1ps
`default_nettype none

module ssw_top
   import ssw_pkg::*;
#(
   parameter int DETECT_CYC = DETECT_CYCLES,
   parameter int BLINK_CYC = BLINK_CYCLES,
   parameter int BIT_CYC = BIT_CYCLES,
   parameter logic [ADDR_W-1:0] NODE_ADDR = 4'h0,
   // Arbitrary value, stands in for a factory serial number.
   parameter logic [31:0] SERIAL_NO = 32'h1234_5678
)(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Sensor core
   input wire logic actuator_present,
   input wire logic unit_ready,
   input wire logic [3:0] teach_remaining,
   input wire logic [7:0] actuator_name,
   // Pins
   input wire logic safety_in_ch1,
   input wire logic safety_in_ch2,
   input wire logic diag_in,
   output logic safety_out_ch1,
   output logic safety_out_ch2,
   output logic signal_diag_out,
   // Indicators
   output logic led_input_yellow,
   output logic plaus_error,
   output logic diag_mode,
   output logic name_refresh_req
);
   localparam int DW = $clog2(DETECT_CYC + 1);
   localparam int BW = $clog2(BLINK_CYC + 1);

   logic [1:0] in1_sync_q;
   logic [1:0] in2_sync_q;
   logic [1:0] diag_sync_q;
   logic in1_s;
   logic in2_s;
   logic diag_s;
   ssw_plaus_t plaus_q;
   logic lock;
   logic unequal;
   logic [DW-1:0] det_cnt_q;
   logic det_done_q;
   logic [BW-1:0] blink_cnt_q;
   logic blink_q;
   logic rx_line;
   logic addr_hit;
   logic [3:0] cmd;
   logic [7:0] status_byte;
   logic [7:0] reply_d;
   logic reply_ok;

   ssw_diag_if link ();

   // ******************
   // Pin synchronisers
   // ******************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         in1_sync_q <= 2'b00;
         in2_sync_q <= 2'b00;
         // The diagnostic line idles high, so resetting its stages low would look
         // like a low line and cancel module detection on every power-up.
         diag_sync_q <= {2{LINE_IDLE}};
      end else begin
         in1_sync_q <= {in1_sync_q[0], safety_in_ch1};
         in2_sync_q <= {in2_sync_q[0], safety_in_ch2};
         diag_sync_q <= {diag_sync_q[0], diag_in};
      end
   end

   assign in1_s = in1_sync_q[1];
   assign in2_s = in2_sync_q[1];
   assign diag_s = diag_sync_q[1];

   // ******************
   // Plausibility
   // ******************
   ssw_plaus u_plaus (
      .clk(clk),
      .reset_n(reset_n),
      .in1(in1_s),
      .in2(in2_s),
      .state_q(plaus_q)
   );

   assign lock = (plaus_q == PL_LOCK);
   assign unequal = (plaus_q != PL_NORMAL);

   // ******************
   // Safety outputs
   // ******************
   // Only presence, readiness, lock and the inputs feed these flops, so a
   // fault anywhere in the diagnostic logic cannot hold an output on.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         safety_out_ch1 <= OUT_RESET;
         safety_out_ch2 <= OUT_RESET;
      end else begin
         safety_out_ch1 <= actuator_present & unit_ready & !lock & in1_s;
         safety_out_ch2 <= actuator_present & unit_ready & !lock & in2_s;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         plaus_error <= 1'b0;
      end else begin
         plaus_error <= lock;
      end
   end

   // ******************
   // Input indicator
   // ******************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         blink_cnt_q <= '0;
         blink_q <= 1'b0;
      end else if (blink_cnt_q == BW'(BLINK_CYC - 1)) begin
         blink_cnt_q <= '0;
         blink_q <= !blink_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         led_input_yellow <= 1'b0;
      end else begin
         led_input_yellow <= unequal & blink_q;
      end
   end

   // ******************
   // Module detection
   // ******************
   // An attached fieldbus module holds the diagnostic line high. The check
   // runs once per reset, so a swapped sensor joins again after power-up.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         det_cnt_q <= '0;
         det_done_q <= 1'b0;
         diag_mode <= 1'b0;
      end else if (!det_done_q) begin
         if (!diag_s) begin
            det_done_q <= 1'b1;
         end else if (det_cnt_q == DW'(DETECT_CYC - 1)) begin
            det_done_q <= 1'b1;
            diag_mode <= 1'b1;
         end else begin
            det_cnt_q <= det_cnt_q + 1'b1;
         end
      end
   end

   // ******************
   // Diagnostic link
   // ******************
   assign rx_line = diag_mode ? diag_s : LINE_IDLE;

   ssw_diag #(.BIT_CYC(BIT_CYC)) u_diag (
      .clk(clk),
      .reset_n(reset_n),
      .rx_line(rx_line),
      .link(link)
   );

   assign addr_hit = (link.rx_byte[ADDR_MSB:ADDR_LSB] == NODE_ADDR);
   assign cmd = link.rx_byte[3:0];
   assign status_byte = {in1_s, in2_s, safety_out_ch1, safety_out_ch2,
                         actuator_present, lock, unequal, unit_ready};

   // Unknown commands set reply_ok low, so the link stays silent rather than
   // answering with a byte that the module could misread.
   always_comb begin
      reply_d = IDLE_BYTE;
      reply_ok = 1'b1;
      case (cmd)
         CMD_STATUS: reply_d = status_byte;
         CMD_TEACH: reply_d = {4'h0, teach_remaining};
         CMD_NAME: reply_d = actuator_name;
         CMD_REFRESH: reply_d = ACK_BYTE;
         default: begin
            if (cmd >= CMD_SERIAL0 && cmd <= CMD_SERIAL3) begin
               reply_d = SERIAL_NO[8 * (cmd - CMD_SERIAL0) +: 8];
            end else begin
               reply_ok = 1'b0;
            end
         end
      endcase
   end

   // A poll arriving while a reply is still going out is dropped; the
   // module repeats it, which keeps the engine free of a queue.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         link.tx_start <= 1'b0;
         link.tx_byte <= IDLE_BYTE;
         name_refresh_req <= 1'b0;
      end else begin
         link.tx_start <= 1'b0;
         name_refresh_req <= 1'b0;
         if (diag_mode && link.rx_valid && addr_hit && reply_ok && !link.tx_busy) begin
            link.tx_start <= 1'b1;
            link.tx_byte <= reply_d;
            name_refresh_req <= (cmd == CMD_REFRESH);
         end
      end
   end

   // ******************
   // Signal output
   // ******************
   // Once a module is found the pin carries frames only, so the plain presence
   // signal is no longer visible on it until the next power-up.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         signal_diag_out <= OUT_RESET;
      end else if (diag_mode) begin
         signal_diag_out <= link.tx_line;
      end else begin
         signal_diag_out <= actuator_present & unit_ready;
      end
   end

   // ******************
   // Checks
   // ******************
   no_actuator_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !actuator_present |=> !safety_out_ch1 && !safety_out_ch2)
      else $error("safety output on without actuator");
   signal_low_a: assert property (@(posedge clk) disable iff (!reset_n)
      !actuator_present && !diag_mode |=> !signal_diag_out)
      else $error("signal output high without actuator");
   outputs_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      actuator_present && unit_ready && !lock |=>
      safety_out_ch1 == $past(in1_s) && safety_out_ch2 == $past(in2_s) && (diag_mode || signal_diag_out))
      else $error("outputs do not follow inputs");
   lock_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      lock |=> !safety_out_ch1 && !safety_out_ch2 && plaus_error)
      else $error("output on while locked");
   diag_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
      !diag_mode |-> !link.tx_start && !name_refresh_req)
      else $error("diagnostic reply without module");
   diag_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
      diag_mode ##1 diag_mode |-> signal_diag_out == $past(link.tx_line))
      else $error("signal pin not carrying diagnostic data");
   addr_match_a: assert property (@(posedge clk) disable iff (!reset_n)
      link.tx_start |-> $past(link.rx_valid) && $past(addr_hit))
      else $error("reply to foreign address");
   refresh_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
      name_refresh_req |-> link.tx_start && link.tx_byte == ACK_BYTE)
      else $error("refresh action not acknowledged");
   // The checks below watch indicator, detection, presence signal and refresh
   // paths that the output checks above do not reach.
   led_normal_a: assert property (@(posedge clk) disable iff (!reset_n)
      plaus_q == PL_NORMAL |=> !led_input_yellow)
      else $error("input indicator lit in normal state");
   error_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      plaus_error |-> $past(lock))
      else $error("plausibility error without lock");
   diag_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
      diag_mode |=> diag_mode)
      else $error("diagnostic mode lost before reset");
   line_low_a: assert property (@(posedge clk) disable iff (!reset_n)
      !det_done_q && !diag_s |=> !diag_mode)
      else $error("diagnostic mode despite low line");
   presence_signal_a: assert property (@(posedge clk) disable iff (!reset_n)
      !diag_mode ##1 !diag_mode |-> signal_diag_out == $past(actuator_present && unit_ready))
      else $error("signal output not following presence");
   refresh_cmd_a: assert property (@(posedge clk) disable iff (!reset_n)
      name_refresh_req |-> $past(cmd) == CMD_REFRESH)
      else $error("refresh pulse without refresh command");
endmodule

`default_nettype wire

// ---- hw/ssw_pkg.sv ----
// Purpose: Shared constants and types of the safety switch output logic.
// Assumes: 100 MHz system clock.
// Notes:   Diagnostic frame layout and codes are local choices.

package ssw_pkg;
   // ************
   // Timing
   // ************
   localparam int CLK_PERIOD_NS = 10;
   localparam int BIT_TIME_NS = 10000;
   localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DETECT_TIME_US = 1000;
   localparam int DETECT_CYCLES = (DETECT_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int BLINK_TIME_MS = 250;
   localparam int BLINK_CYCLES = (BLINK_TIME_MS * 1000000) / CLK_PERIOD_NS;

   // ************
   // Diagnostic chain and commands
   // ************
   localparam int MAX_NODES = 16;
   localparam int ADDR_W = 4;
   localparam int ADDR_MSB = 7;
   localparam int ADDR_LSB = 4;
   localparam logic [3:0] CMD_STATUS = 4'h1;
   localparam logic [3:0] CMD_TEACH = 4'h2;
   localparam logic [3:0] CMD_SERIAL0 = 4'h3;
   localparam logic [3:0] CMD_SERIAL3 = 4'h6;
   localparam logic [3:0] CMD_NAME = 4'h7;
   localparam logic [3:0] CMD_REFRESH = 4'h8;
   localparam logic [7:0] ACK_BYTE = 8'hA5;
   localparam logic [7:0] IDLE_BYTE = 8'h00;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic OUT_RESET = 1'b0;

   typedef enum logic [1:0] {PL_NORMAL, PL_UNEQUAL, PL_LOCK} ssw_plaus_t;
   typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} ssw_rx_t;
endpackage

// ---- hw/ssw_diag_if.sv ----
// Purpose: Byte level carrier between serial engine and command logic.
// Assumes: One clock domain.
// Notes:   tx_start is taken only while tx_busy is low.

`timescale 1ns/1ps
`default_nettype none

interface ssw_diag_if;
   logic rx_valid;
   logic [7:0] rx_byte;
   logic tx_start;
   logic [7:0] tx_byte;
   logic tx_busy;
   logic tx_line;

   modport serial (output rx_valid, output rx_byte, output tx_busy, output tx_line,
                   input tx_start, input tx_byte);
   modport core (input rx_valid, input rx_byte, input tx_busy, input tx_line,
                 output tx_start, output tx_byte);
endinterface

`default_nettype wire

// ---- hw/ssw_plaus.sv ----
// Purpose: Plausibility monitor of the two series chain safety inputs.
// Assumes: Inputs already synchronised to clk.
// Notes:   Lock leaves only through a joint low of both inputs.

`timescale 1ns/1ps
`default_nettype none

module ssw_plaus
   import ssw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Synchronised inputs
   input wire logic in1,
   input wire logic in2,
   // State
   output var ssw_plaus_t state_q
);
   logic both_hi_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         both_hi_q <= 1'b0;
      end else begin
         both_hi_q <= in1 & in2;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= PL_NORMAL;
      end else begin
         case (state_q)
            PL_NORMAL: if (both_hi_q && (in1 ^ in2)) state_q <= PL_UNEQUAL;
            PL_UNEQUAL: begin
               if (!in1 && !in2) begin
                  state_q <= PL_NORMAL;
               end else if (in1 && in2) begin
                  state_q <= PL_LOCK;
               end
            end
            PL_LOCK: if (!in1 && !in2) state_q <= PL_NORMAL;
            default: state_q <= PL_LOCK;
         endcase
      end
   end

   unequal_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      state_q == PL_NORMAL && both_hi_q && (in1 ^ in2) |=> state_q == PL_UNEQUAL)
      else $error("single falling input not flagged");
   lock_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
      state_q == PL_UNEQUAL && in1 && in2 |=> state_q == PL_LOCK)
      else $error("lone input rise did not lock");
   lock_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      state_q != PL_NORMAL |=> state_q != PL_NORMAL || (!$past(in1) && !$past(in2)))
      else $error("left plausibility state without joint low");
endmodule

`default_nettype wire

// ---- hw/ssw_diag.sv ----
// Purpose: Serial engine of the diagnostic link, 8N1, LSB first.
// Assumes: rx_line is synchronised and held high when unused.
// Notes:   A frame with a low stop bit is dropped silently.

`timescale 1ns/1ps
`default_nettype none

module ssw_diag
   import ssw_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYCLES
)(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Line
   input wire logic rx_line,
   // Byte side
   ssw_diag_if.serial link
);
   // Room for one and a half bit times, which the receiver loads after a start edge.
   localparam int CW = $clog2(2 * BIT_CYC);
   localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
   localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);

   ssw_rx_t rx_st_q;
   logic [CW-1:0] rx_cnt_q;
   logic [2:0] rx_bit_q;
   logic [7:0] rx_sh_q;
   logic [CW-1:0] tx_cnt_q;
   logic [3:0] tx_left_q;
   logic [8:0] tx_sh_q;

   // ************
   // Receiver
   // ************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_st_q <= RX_IDLE;
         rx_cnt_q <= '0;
         rx_bit_q <= 3'h0;
         rx_sh_q <= 8'h00;
         link.rx_valid <= 1'b0;
         link.rx_byte <= 8'h00;
      end else begin
         link.rx_valid <= 1'b0;
         case (rx_st_q)
            RX_IDLE: begin
               rx_cnt_q <= HALF + FULL;
               rx_bit_q <= 3'h0;
               if (!rx_line) rx_st_q <= RX_DATA;
            end
            RX_DATA: begin
               if (rx_cnt_q != '0) begin
                  rx_cnt_q <= rx_cnt_q - 1'b1;
               end else begin
                  rx_cnt_q <= FULL;
                  rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 1'b1;
                  if (rx_bit_q == 3'h7) rx_st_q <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_cnt_q != '0) begin
                  rx_cnt_q <= rx_cnt_q - 1'b1;
               end else begin
                  rx_st_q <= RX_IDLE;
                  link.rx_valid <= rx_line;
                  link.rx_byte <= rx_sh_q;
               end
            end
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // ************
   // Transmitter
   // ************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_cnt_q <= '0;
         tx_left_q <= 4'h0;
         tx_sh_q <= 9'h1FF;
         link.tx_line <= LINE_IDLE;
         link.tx_busy <= 1'b0;
      end else if (!link.tx_busy) begin
         if (link.tx_start) begin
            link.tx_line <= 1'b0;
            tx_sh_q <= {1'b1, link.tx_byte};
            tx_left_q <= 4'h9;
            tx_cnt_q <= FULL;
            link.tx_busy <= 1'b1;
         end
      end else if (tx_cnt_q != '0) begin
         tx_cnt_q <= tx_cnt_q - 1'b1;
      end else if (tx_left_q == 4'h0) begin
         link.tx_busy <= 1'b0;
      end else begin
         link.tx_line <= tx_sh_q[0];
         tx_sh_q <= {1'b1, tx_sh_q[8:1]};
         tx_left_q <= tx_left_q - 1'b1;
         tx_cnt_q <= FULL;
      end
   end

   tx_start_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
      link.tx_start && !link.tx_busy |=> !link.tx_line && link.tx_busy)
      else $error("start bit not sent");
endmodule

`default_nettype wire

// ---- test/ssw_fieldbus_model.sv ----
// Purpose: Model of the diagnostic fieldbus module at the far end of the link.
// Assumes: 8N1 frames, LSB first, BIT_CYC clock cycles per bit.
// Notes:   A detached line toggles every cycle, as a floating wire might.

`timescale 1ns/1ps
`default_nettype none

module ssw_fieldbus_model #(
   parameter int BIT_CYC = 8
)(
   // Clock
   input wire logic clk,
   // Attachment
   input wire logic attached,
   // Link pins
   input wire logic signal_diag_out,
   output logic diag_in
);
   logic line_q = 1'b1;
   logic noise_q = 1'b0;

   // ************
   // Line
   // ************
   // A powered module holds the line idle high from power-up on, so the sensor finds it again.
   always @(posedge clk) noise_q <= ~noise_q;
   assign diag_in = attached ? line_q : noise_q;

   // ************
   // Frames
   // ************
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         line_q <= f[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
   endtask

   task automatic recv_byte(output logic [7:0] b, output logic ok);
      int w;
      b = 8'h00;
      ok = 1'b0;
      w = 0;
      while (signal_diag_out !== 1'b0 && w < 14 * BIT_CYC) begin
         @(posedge clk);
         #1;
         w++;
      end
      if (w < 14 * BIT_CYC) begin
         repeat (BIT_CYC / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            b[i] = signal_diag_out;
         end
         repeat (BIT_CYC) @(posedge clk);
         ok = (signal_diag_out === 1'b1);
      end
   endtask

   // The address nibble of req selects one of up to sixteen chained sensors.
   task automatic poll(input logic [7:0] req, output logic [7:0] b, output logic ok);
      fork
         send_byte(req);
         recv_byte(b, ok);
      join
      repeat (BIT_CYC) @(posedge clk);
   endtask
endmodule

`default_nettype wire

// ---- test/ssw_top_test.sv ----
// Purpose: Self-checking bench of the safety switch output logic.
// Assumes: Short counts for detection, blink and bit time.
// Notes:   Inputs pass through both low between random vectors to avoid a lock.

`timescale 1ns/1ps
`default_nettype none

module ssw_top_test;
   import ssw_pkg::*;
   localparam int DET = 20;
   localparam int BLK = 4;
   localparam int BITC = 8;
   localparam int LIMIT = 20000;
   // Arbitrary value.
   localparam logic [31:0] SER = 32'h1234_5678;
   logic clk, reset_n, present, ready, in1, in2, attached;
   logic [3:0] teach;
   logic [7:0] name, got, req, exp;
   logic out1, out2, sig, diag_in, led, perr, dmode, refresh, ok;
   logic [31:0] rnd;
   int err_total, n_tests, cyc, n_refresh, hi;

   ssw_top #(.DETECT_CYC(DET), .BLINK_CYC(BLK), .BIT_CYC(BITC), .NODE_ADDR(4'h0), .SERIAL_NO(SER)) ssw_top_i (
      .clk(clk), .reset_n(reset_n), .actuator_present(present), .unit_ready(ready),
      .teach_remaining(teach), .actuator_name(name), .safety_in_ch1(in1), .safety_in_ch2(in2),
      .diag_in(diag_in), .safety_out_ch1(out1), .safety_out_ch2(out2), .signal_diag_out(sig),
      .led_input_yellow(led), .plaus_error(perr), .diag_mode(dmode), .name_refresh_req(refresh));

   ssw_fieldbus_model #(.BIT_CYC(BITC)) ssw_fieldbus_model_i (
      .clk(clk), .attached(attached), .signal_diag_out(sig), .diag_in(diag_in));

   // ************
   // Helpers
   // ************
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
   endfunction

   function automatic logic [7:0] status_exp(input logic a, b, p, r);
      return {a, b, a & p & r, b & p & r, p, 1'b0, 1'b0, r};
   endfunction

   task automatic check1(input string what, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %b seen %b", what, e, g);
      end
   endtask

   task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Pin to output takes three cycles; five leave margin.
   task automatic drive(input logic p, r, a, b);
      @(posedge clk);
      present <= p;
      ready <= r;
      in1 <= a;
      in2 <= b;
      step(5);
   endtask

   task automatic blink();
      hi = 0;
      repeat (12) begin
         step(1);
         if (led === 1'b1) hi++;
      end
   endtask

   task automatic do_reset(input logic att);
      @(posedge clk);
      reset_n <= 1'b0;
      attached <= att;
      step(9);
      check1("out_in_reset", 1'b0, out1);
      @(posedge clk);
      reset_n <= 1'b1;
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ************
   // Clock and watchdog
   // ************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (refresh === 1'b1) n_refresh++;
      if (cyc == LIMIT) begin
         err_total++;
         finish_test();
      end
   end

   // ************
   // Main sequence
   // ************
   initial begin
      {reset_n, attached} = 2'b00;
      {present, ready, in1, in2} = 4'b1111;
      teach = 4'h0;
      name = 8'h00;
      rnd = 32'h328A_C44E;
      do_reset(1'b0);
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr_next(rnd);
         drive(1'b1, 1'b1, 1'b0, 1'b0);
         drive(rnd[0] | rnd[1], rnd[2] | rnd[3], rnd[4], rnd[5]);
         check1("out_ch1", rnd[4] & present & ready, out1);
         check1("out_ch2", rnd[5] & present & ready, out2);
         check1("signal_out", present & ready, sig);
         check1("diag_mode_off", 1'b0, dmode);
      end
      $display("test safety path done");
      drive(1'b1, 1'b1, 1'b1, 1'b1);
      drive(1'b1, 1'b1, 1'b1, 1'b0);
      check1("unequal_out1", 1'b1, out1);
      check1("unequal_out2", 1'b0, out2);
      check1("unequal_err", 1'b0, perr);
      blink();
      check1("unequal_led", 1'b1, hi > 0 && hi < 12);
      drive(1'b1, 1'b1, 1'b1, 1'b1);
      check1("lock_err", 1'b1, perr);
      check1("lock_out1", 1'b0, out1);
      check1("lock_out2", 1'b0, out2);
      blink();
      check1("lock_led", 1'b1, hi > 0 && hi < 12);
      drive(1'b1, 1'b1, 1'b0, 1'b1);
      drive(1'b1, 1'b1, 1'b1, 1'b1);
      check1("lock_held", 1'b1, perr);
      drive(1'b1, 1'b1, 1'b0, 1'b0);
      drive(1'b1, 1'b1, 1'b1, 1'b1);
      check1("unlock_err", 1'b0, perr);
      check1("unlock_out", 1'b1, out1 & out2);
      check1("unlock_led", 1'b0, led);
      $display("test plausibility done");
      rnd = lfsr_next(rnd);
      @(posedge clk);
      teach <= rnd[3:0];
      name <= rnd[15:8];
      do_reset(1'b1);
      step(DET + 10);
      check1("diag_mode_on", 1'b1, dmode);
      check1("tx_idle", LINE_IDLE, sig);
      for (int c = 1; c <= 8; c++) begin
         case (c)
            1: exp = status_exp(1'b1, 1'b1, 1'b1, 1'b1);
            2: exp = {4'h0, teach};
            7: exp = name;
            8: exp = ACK_BYTE;
            default: exp = SER[(c - 3) * 8 +: 8];
         endcase
         req = {4'h0, 4'(c)};
         ssw_fieldbus_model_i.poll(req, got, ok);
         check1("reply_seen", 1'b1, ok);
         check8("reply_byte", exp, got);
      end
      check1("refresh_pulse", 1'b1, n_refresh == 1);
      ssw_fieldbus_model_i.poll(8'h11, got, ok);
      check1("other_addr", 1'b0, ok);
      ssw_fieldbus_model_i.poll(8'h0F, got, ok);
      check1("unknown_cmd", 1'b0, ok);
      drive(1'b1, 1'b1, 1'b0, 1'b0);
      drive(1'b1, 1'b1, 1'b1, 1'b0);
      check1("diag_out1", 1'b1, out1);
      check1("diag_out2", 1'b0, out2);
      $display("test diagnostics done");
      finish_test();
   end
endmodule

`default_nettype wire
